// File: logic/nbad_pkg.sv
package nbad_pkg;
    // register offset in special-function space
    localparam logic [7:0] NBAD_MEMORY_MAP_CONFIG_OFS = 8'hC6;
    // field positions of memory_map_config
    localparam int NBAD_PART_LSB    = 4;
    localparam int NBAD_RANGE_BIT   = 3;
    localparam int NBAD_AUX_BIT     = 2;
    localparam int NBAD_UNLOCK_BIT  = 1;
    // reset values: nonvolatile fields after first power-up, unlock bit on ordinary reset
    localparam logic [3:0] NBAD_PART_RST   = 4'hF;
    localparam logic       NBAD_RANGE_RST  = 1'b1;
    localparam logic       NBAD_AUX_RST    = 1'b0;
    localparam logic       NBAD_UNLOCK_RST = 1'b0;
    // address limits
    localparam logic [15:0] NBAD_RANGE_8K   = 16'h2000;
    localparam logic [15:0] NBAD_RANGE_32K  = 16'h8000;
    localparam logic [15:0] NBAD_PART_LAST  = 16'h8000;
    localparam logic [15:0] NBAD_PART_LOCKD = 16'h7FFF;
    localparam logic [3:0]  NBAD_PART_CODE_MAX = 4'hF;

    typedef enum logic [1:0] {
        NBAD_ROUTE_IDLE = 2'b00,
        NBAD_ROUTE_BW1  = 2'b01,
        NBAD_ROUTE_BW2  = 2'b11,
        NBAD_ROUTE_EXP  = 2'b10
    } nbad_route_t;

    typedef struct packed {
        logic        valid;
        logic        is_data;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } nbad_access_t;

    typedef struct packed {
        logic [14:0] addr;
        logic [7:0]  wdata;
        logic        drive;
        logic        write_n;
        logic        ce1_n;
        logic        ce2_n;
    } nbad_bw_bus_t;
endpackage

// File: logic/nbad_decoder.sv
`timescale 1ns/1ps
// How it works
// - program and data spaces are separate 64K areas chosen by access type
// - program space is never written; data space accepts reads and writes
// - byte-wide bus has 15 address, 8 data, one strobe, two RAM selects
// - config bit 3 picks RAM size: 0 is 8K, 1 is 32K
// - range bit only written during bootstrap loading
// - primary RAM split at partition: program below, data at and above
// - partition steps are 2K each except the last, which is 4K
// - partition writable during loading and by application software
// - secondary select serves data only, switched by config bit 2
// - byte-wide bus used for the three documented address cases
// - aux-forced data access asserts secondary select, primary stays off
// - aux enable has no effect on program fetches
// - everything else goes to the expanded bus on ports 0 and 2
// - expanded bus is plain multiplexed bus with no protection
// - partition, range and aux fields keep their value across power loss
// - partition codes 0 to 14 map in 2K steps, 15 maps to 8000h
// - partition writable only with unlock set; unlock needs timed access
// - external-access pin low forces expanded bus unless locked
// - lock with partition zero forces effective partition to 7FFFh
module nbad_decoder
    import nbad_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    input  wire logic         por_no_backup,
    input  wire logic         program_load_mode,
    input  wire logic         security_lock_bit,
    input  wire logic         timed_access_open,
    input  wire logic         external_access_pin,
    input  wire logic         sfr_wr,
    input  wire logic [7:0]   sfr_addr,
    input  wire logic [7:0]   sfr_wdata,
    input  wire nbad_access_t acc,
    output logic [7:0]        memory_map_config_rd,
    output nbad_bw_bus_t      bw_bus,
    output logic              exp_bus_sel,
    output logic [15:0]       exp_bus_addr,
    output logic              exp_bus_write,
    output logic [7:0]        exp_bus_wdata
);
    logic [3:0]  partition_field_r;
    logic        range_size_select_r;
    logic        aux_ram_select_enable_r;
    logic        partition_write_unlock_r;
    logic        lock_prev_r;
    logic [2:0]  ext_sync_r;
    logic        ext_low_r;
    logic        cfg_hit;
    logic [15:0] part_addr;
    logic [15:0] eff_part;
    logic [15:0] range_addr;
    nbad_route_t route_nxt;
    nbad_bw_bus_t bw_nxt;

    assign cfg_hit = sfr_wr && (sfr_addr == NBAD_MEMORY_MAP_CONFIG_OFS);

    // partition, range and aux are held in battery-backed flops: only a power-up without backup
    // or, for partition and range, clearing the lock reinitialises them; the unlock bit clears on the ordinary reset
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lock_prev_r <= 1'b0;
        end else begin
            lock_prev_r <= security_lock_bit;
        end
    end

    always_ff @(posedge core_clk) begin
        if (por_no_backup || (lock_prev_r && !security_lock_bit)) begin
            partition_field_r   <= NBAD_PART_RST;
            range_size_select_r <= NBAD_RANGE_RST;
        end else if (cfg_hit) begin
            if (partition_write_unlock_r) begin
                // clearing to zero while locked is illegal and lands on all ones
                if (security_lock_bit && sfr_wdata[NBAD_PART_LSB +: 4] == 4'h0) begin
                    partition_field_r <= NBAD_PART_RST;
                end else begin
                    partition_field_r <= sfr_wdata[NBAD_PART_LSB +: 4];
                end
            end
            if (program_load_mode) begin
                range_size_select_r <= sfr_wdata[NBAD_RANGE_BIT];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (por_no_backup) begin
            aux_ram_select_enable_r <= NBAD_AUX_RST;
        end else if (cfg_hit) begin
            aux_ram_select_enable_r <= sfr_wdata[NBAD_AUX_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            partition_write_unlock_r <= NBAD_UNLOCK_RST;
        end else if (cfg_hit && timed_access_open) begin
            partition_write_unlock_r <= sfr_wdata[NBAD_UNLOCK_BIT];
        end
    end

    // pin from outside: three flops, change accepted once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ext_sync_r <= 3'b111;
            ext_low_r  <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], external_access_pin};
            if (ext_sync_r[1] == ext_sync_r[2]) begin
                ext_low_r <= ~ext_sync_r[2];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            memory_map_config_rd <= 8'h00;
        end else begin
            memory_map_config_rd <= {partition_field_r, range_size_select_r,
                                     aux_ram_select_enable_r, partition_write_unlock_r, 1'b0};
        end
    end

    always_comb begin
        // code 15 is a 4K jump to 8000h, all others are 2K multiples
        if (partition_field_r == NBAD_PART_CODE_MAX) begin
            part_addr = NBAD_PART_LAST;
        end else begin
            part_addr = {1'b0, partition_field_r, 11'h000};
        end
        if (security_lock_bit && partition_field_r == 4'h0) begin
            eff_part = NBAD_PART_LOCKD;
        end else begin
            eff_part = part_addr;
        end
        range_addr = range_size_select_r ? NBAD_RANGE_32K : NBAD_RANGE_8K;
    end

    // decode is combinational on the current access; the flops below only register outputs
    always_comb begin
        route_nxt = NBAD_ROUTE_IDLE;
        if (acc.valid) begin
            route_nxt = NBAD_ROUTE_EXP;
            if (ext_low_r && !security_lock_bit) begin
                route_nxt = NBAD_ROUTE_EXP;
            end else if (!acc.is_data) begin
                // a fetch also clears range limit; aux bit not consulted
                if (acc.addr < eff_part && acc.addr < range_addr) begin
                    route_nxt = NBAD_ROUTE_BW1;
                end
            end else if (aux_ram_select_enable_r && acc.addr < range_addr) begin
                route_nxt = NBAD_ROUTE_BW2;
            end else if (acc.addr >= eff_part && acc.addr < range_addr) begin
                route_nxt = NBAD_ROUTE_BW1;
            end
        end
        bw_nxt.addr    = acc.addr[14:0];
        bw_nxt.wdata   = acc.wdata;
        bw_nxt.write_n = ~(acc.write && acc.is_data && route_nxt != NBAD_ROUTE_IDLE
                           && route_nxt != NBAD_ROUTE_EXP);
        bw_nxt.drive   = ~bw_nxt.write_n;
        bw_nxt.ce1_n   = (route_nxt != NBAD_ROUTE_BW1);
        bw_nxt.ce2_n   = (route_nxt != NBAD_ROUTE_BW2);
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            bw_bus        <= '{addr: 15'h0000, wdata: 8'h00, drive: 1'b0,
                               write_n: 1'b1, ce1_n: 1'b1, ce2_n: 1'b1};
            exp_bus_sel   <= 1'b0;
            exp_bus_addr  <= 16'h0000;
            exp_bus_write <= 1'b0;
            exp_bus_wdata <= 8'h00;
        end else begin
            bw_bus        <= bw_nxt;
            exp_bus_sel   <= (route_nxt == NBAD_ROUTE_EXP);
            exp_bus_addr  <= acc.addr;
            exp_bus_write <= (route_nxt == NBAD_ROUTE_EXP) && acc.write && acc.is_data;
            exp_bus_wdata <= acc.wdata;
        end
    end

    AST_NO_PROG_WRITE: assert property (@(posedge core_clk) disable iff (!reset_n)
        (acc.valid && !acc.is_data) |=> (bw_bus.write_n && !exp_bus_write))
        else $error("program access produced a write");
    AST_CE_EXCLUSIVE: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(!bw_bus.ce1_n && !bw_bus.ce2_n))
        else $error("both ram selects active");
    AST_AUX_DATA: assert property (@(posedge core_clk) disable iff (!reset_n)
        (acc.valid && !acc.is_data) |=> bw_bus.ce2_n)
        else $error("secondary select on program fetch");
    AST_EXT_FORCE: assert property (@(posedge core_clk) disable iff (!reset_n)
        (acc.valid && ext_low_r && !security_lock_bit) |=> (exp_bus_sel && bw_bus.ce1_n && bw_bus.ce2_n))
        else $error("external pin low did not force expanded bus");
    AST_ROUTE_ONE: assert property (@(posedge core_clk) disable iff (!reset_n)
        acc.valid |=> (exp_bus_sel ^ (!bw_bus.ce1_n || !bw_bus.ce2_n)))
        else $error("access not routed to exactly one bus");
    AST_RANGE_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!program_load_mode && !por_no_backup && !(lock_prev_r && !security_lock_bit))
        |=> $stable(range_size_select_r))
        else $error("range changed outside loading");
    AST_PART_LOCKED: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!partition_write_unlock_r && !por_no_backup && !(lock_prev_r && !security_lock_bit))
        |=> $stable(partition_field_r))
        else $error("partition changed while not unlocked");
    AST_LOCK_PART: assert property (@(posedge core_clk) disable iff (!reset_n)
        (acc.valid && !acc.is_data && security_lock_bit && partition_field_r == 4'h0
         && acc.addr < range_addr) |=> !bw_bus.ce1_n)
        else $error("locked zero partition not forced to program");
    AST_PROG_BELOW: assert property (@(posedge core_clk) disable iff (!reset_n)
        (acc.valid && !acc.is_data && !ext_low_r && acc.addr < part_addr && acc.addr < range_addr)
        |=> !bw_bus.ce1_n)
        else $error("program fetch below partition not on byte-wide bus");
    // nothing past the range may reach the ram, whatever partition or aux setting says
    AST_RANGE_LIMIT: assert property (@(posedge core_clk) disable iff (!reset_n)
        (acc.valid && acc.addr >= range_addr) |=> (bw_bus.ce1_n && bw_bus.ce2_n))
        else $error("access beyond range reached byte-wide bus");
    AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (!reset_n)
        !acc.valid |=> (bw_bus.ce1_n && bw_bus.ce2_n && !exp_bus_sel))
        else $error("bus selected without an access");
endmodule

// File: dv/nbad_sram_model.sv
`timescale 1ns/1ps
module nbad_sram_model
    import nbad_pkg::*;
(
    input wire logic         core_clk,
    input wire nbad_bw_bus_t bw_bus
);
    logic [7:0] mem1 [0:32767];
    logic [7:0] mem2 [0:32767];
    // write-only view: the block has no read-data return path to model
    always @(posedge core_clk) begin
        if (!bw_bus.write_n && !bw_bus.ce1_n) begin
            mem1[bw_bus.addr] <= bw_bus.wdata;
        end
        if (!bw_bus.write_n && !bw_bus.ce2_n) begin
            mem2[bw_bus.addr] <= bw_bus.wdata;
        end
    end
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import nbad_pkg::*;
    logic         core_clk = 0, reset_n = 0, por = 1, load = 0, lock = 0, ta = 0, ext = 1, sfr_wr = 0;
    logic [7:0]   sfr_wdata = 8'h00, sfr_addr = 8'hC6, cfg_rd, exp_wdata;
    nbad_access_t acc = '0;
    nbad_bw_bus_t bw_bus;
    logic         exp_sel, exp_write;
    logic [15:0]  exp_addr, a;
    int           n_fail = 0, checks = 0;
    // bench view of the configuration, kept from the rules
    logic [3:0]   pc = 4'hF;
    logic         rng = 1, aux = 0, unl = 0;

    always #10 core_clk = ~core_clk;

    nbad_decoder i_nbad_decoder (.core_clk(core_clk), .reset_n(reset_n), .por_no_backup(por),
        .program_load_mode(load), .security_lock_bit(lock), .timed_access_open(ta),
        .external_access_pin(ext), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .acc(acc),
        .memory_map_config_rd(cfg_rd), .bw_bus(bw_bus), .exp_bus_sel(exp_sel), .exp_bus_addr(exp_addr),
        .exp_bus_write(exp_write), .exp_bus_wdata(exp_wdata));
    nbad_sram_model i_nbad_sram_model (.core_clk(core_clk), .bw_bus(bw_bus));

    task automatic conclude;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("BAD t=%0t %s", $time, m);
        end
    endtask

    function automatic nbad_route_t route(input logic d, input logic [15:0] x);
        logic [15:0] eff, lim;
        eff = (pc == 4'hF) ? NBAD_PART_LAST : {1'b0, pc, 11'h000};
        if (lock && pc == 4'h0) eff = NBAD_PART_LOCKD;
        lim = rng ? NBAD_RANGE_32K : NBAD_RANGE_8K;
        if (!ext && !lock) return NBAD_ROUTE_EXP;
        if (!d) return (x < eff && x < lim) ? NBAD_ROUTE_BW1 : NBAD_ROUTE_EXP;
        if (aux && x < lim) return NBAD_ROUTE_BW2;
        return (x >= eff && x < lim) ? NBAD_ROUTE_BW1 : NBAD_ROUTE_EXP;
    endfunction

    // one write to the config register, then wait for the read-back to settle
    task automatic cfg(input logic [7:0] v, input logic t);
        // the unlock bit only follows a write made inside the timed-access window
        if (t && sfr_addr == NBAD_MEMORY_MAP_CONFIG_OFS) unl = v[1];
        @(posedge core_clk); #1;
        sfr_wr = 1; sfr_wdata = v; ta = t;
        @(posedge core_clk); #1;
        sfr_wr = 0; ta = 0;
        @(posedge core_clk); #1;
        chk(cfg_rd === {pc, rng, aux, unl, 1'b0}, "config readback");
    endtask

    task automatic go(input logic d, input logic w, input logic [15:0] x);
        nbad_route_t r;
        r = route(d, x);
        @(posedge core_clk); #1;
        acc = '{1'b1, d, w, x, 8'hA5};
        @(posedge core_clk); #1;
        acc = '0;
        chk(bw_bus.ce1_n === (r != NBAD_ROUTE_BW1) && bw_bus.ce2_n === (r != NBAD_ROUTE_BW2)
            && exp_sel === (r == NBAD_ROUTE_EXP), "route");
        chk(bw_bus.write_n === !(w && d && r != NBAD_ROUTE_EXP)
            && bw_bus.drive === (w && d && r != NBAD_ROUTE_EXP), "strobe");
        if (r != NBAD_ROUTE_EXP) chk(bw_bus.addr === x[14:0] && bw_bus.wdata === 8'hA5, "address");
        else chk(exp_addr === x && exp_wdata === 8'hA5 && exp_write === (w && d), "expanded bus");
    endtask

    task automatic t_regs;
        chk(cfg_rd === 8'hF8, "reset value");
        cfg(8'h02, 0);
        cfg(8'h02, 1);
        pc = 4'h3;
        cfg(8'h32, 0);
        // a write to a neighbouring address must leave the configuration alone
        sfr_addr = 8'hC7;
        cfg(8'h00, 0);
        sfr_addr = 8'hC6;
    endtask

    task automatic t_decode;
        go(0, 0, 16'h17FF);
        go(0, 0, 16'h1800);
        go(1, 0, 16'h1800);
        go(1, 0, 16'h17FF);
        go(1, 1, 16'h7FFF);
        // the ram model takes the registered strobe one edge later
        @(posedge core_clk); #1;
        chk(i_nbad_sram_model.mem1[15'h7FFF] === 8'hA5, "data write");
        go(0, 1, 16'h0100);
        @(posedge core_clk); #1;
        chk(i_nbad_sram_model.mem1[15'h0100] !== 8'hA5, "program write");
        go(1, 1, 16'hF000);
        go(0, 1, 16'h1800);
        aux = 1;
        cfg(8'h3E, 0);
        go(1, 1, 16'h0100);
        @(posedge core_clk); #1;
        chk(i_nbad_sram_model.mem2[15'h0100] === 8'hA5, "aux write");
        go(0, 0, 16'h0100);
        aux = 0;
        cfg(8'h3A, 0);
    endtask

    task automatic t_codes;
        for (int i = 0; i < 16; i++) begin
            pc = 4'(i);
            cfg({pc, 4'hA}, 0);
            a = (pc == 4'hF) ? 16'h8000 : {1'b0, pc, 11'h000};
            go(0, 0, a - 16'h0001);
            go(1, 0, a);
        end
    endtask

    task automatic t_range;
        load = 1; rng = 0; pc = 4'h1;
        cfg(8'h12, 0);
        go(1, 0, 16'h1FFF);
        go(1, 0, 16'h2000);
        load = 0;
        cfg(8'h1A, 0);
    endtask

    task automatic t_ext_lock;
        ext = 0;
        repeat (6) @(posedge core_clk);
        go(0, 0, 16'h0000);
        go(1, 0, 16'h1FFF);
        @(posedge core_clk); #1;
        // zero partition first, then lock: the lock must lift it to 7FFFh and override the pin
        pc = 4'h0;
        cfg(8'h02, 0);
        lock = 1;
        go(0, 0, 16'h1000);
        go(1, 0, 16'h1000);
        pc = 4'hF;
        cfg(8'h02, 0);
        go(0, 0, 16'h0000);
        go(0, 0, 16'h1FFF);
        // clearing the lock reinitialises partition and range
        lock = 0; rng = 1;
        cfg(8'hF2, 0);
    endtask

    initial begin
        #500000;
        n_fail++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge core_clk);
        #1;
        reset_n = 1; por = 0;
        repeat (2) @(posedge core_clk);
        #1;
        t_regs();
        t_decode();
        t_codes();
        t_range();
        t_ext_lock();
        conclude();
    end
endmodule
